// [src/stpf_filter.sv]
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`default_nettype none
module stpf_filter
   import stpf_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic [stpf_pkg::AW-1:0] paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [stpf_pkg::DW-1:0] pwdata,
   input  wire logic [3:0]              pstrb,
   output logic [stpf_pkg::DW-1:0]      prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [stpf_pkg::NPORT-1:0] port_sof,
   input  wire logic [stpf_pkg::NPORT-1:0] port_eof,
   input  wire logic                    fwd_req,
   input  wire logic [stpf_pkg::PIW-1:0] fwd_src,
   input  wire logic [stpf_pkg::NPORT-1:0] fwd_dmap,
   input  wire logic                    fwd_ovr,
   input  wire logic [stpf_pkg::TT_W-1:0] fwd_tag,
   output logic                         fwd_vld,
   output logic [stpf_pkg::NPORT-1:0]   fwd_map,
   output logic                         fwd_learn,
   output logic                         fwd_drop,
   output logic                         flush_stb,
   output logic [stpf_pkg::NPORT-1:0]   flush_map,
   output logic                         host_vld,
   output logic [stpf_pkg::PIW-1:0]     host_idx
);

   // ***********************************
   // Helpers
   // ***********************************
   // Lowest tail-tagged port is the host; others lose that role
   function automatic logic [PIW:0] find_host(input logic [NPORT-1:0] tt);
      find_host = '0;
      for (int i = NPORT - 1; i >= 0; i--) begin
         if (tt[i]) find_host = {1'b1, PIW'(i)};
      end
   endfunction

   function automatic stpf_mode_t mode_of(input logic [2:0] enc);
      case (enc)
         ENC_DISCARD: mode_of = STPF_DISCARD;
         ENC_LEARN:   mode_of = STPF_LEARN;
         ENC_FWD:     mode_of = STPF_FWD;
         default:     mode_of = STPF_ODD;
      endcase
   endfunction

   stpf_bank_if bk ();

   stpf_port_bank u_bank (
      .pclk    (pclk),
      .presetn (presetn),
      .bk      (bk.bank)
   );

   // ***********************************
   // APB decode
   // ***********************************
   logic [CW-1:0]    ctrl_q [NPORT];
   logic [DW-1:0]    rdata_q;
   logic             err_q;
   logic [NPORT-1:0] flush_map_q;
   logic [NPORT-1:0] flush_rej_q;
   logic             flush_stb_q;

   wire             setup   = psel && !penable;
   wire             access  = psel && penable;
   wire             aligned = paddr[1:0] == 2'h0;
   wire [PIW-1:0]   cidx    = paddr[IDX_MSB:IDX_LSB];
   wire             ctrl_hit = aligned && paddr < ADR_STATUS;
   wire             stat_hit = paddr == ADR_STATUS;
   wire             host_hit = paddr == ADR_HOST;
   wire             fl_hit   = paddr == ADR_FLUSH;
   wire             any_hit  = ctrl_hit || stat_hit || host_hit || fl_hit;
   wire             wr_lane0 = access && pwrite && pstrb[0];
   wire             fl_wr    = wr_lane0 && fl_hit;

   // Zero wait states: data was staged in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = access && err_q;
   assign prdata  = rdata_q;

   // ***********************************
   // Port control registers
   // ***********************************
   logic [NPORT-1:0] cfg_tt;
   logic [PIW:0]     host_w;
   logic [NPORT-1:0] host_bit;
   logic [DW-1:0]    stat_word;

   for (genvar p = 0; p < NPORT; p++) begin : g_ctrl
      wire we = wr_lane0 && ctrl_hit && cidx == PIW'(p);

      // three state bits plus tail-tag enable per port
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctrl_q[p] <= CTRL_RST;
         end else if (we) begin
            ctrl_q[p] <= pwdata[CW-1:0];
         end
      end

      assign bk.cfg_tx[p] = ctrl_q[p][B_TXEN];
      assign bk.cfg_rx[p] = ctrl_q[p][B_RXEN];
      assign bk.cfg_ld[p] = ctrl_q[p][B_LDIS];
      assign cfg_tt[p]    = ctrl_q[p][B_TTEN];
      assign stat_word[p*ST_MODE_W +: ST_MODE_W] =
         mode_of({bk.eff_ld[p], bk.eff_rx[p], bk.eff_tx[p]});
   end

   assign stat_word[ST_BUSY_LSB-1:NPORT*ST_MODE_W] = '0;
   assign stat_word[ST_BUSY_LSB +: NPORT] = bk.busy;
   assign stat_word[DW-1:ST_BUSY_LSB+NPORT] = '0;
   assign bk.sof = port_sof;
   assign bk.eof = port_eof;

   // host port chosen by tail tagging
   assign host_w   = find_host(cfg_tt);
   assign host_vld = host_w[PIW];
   assign host_idx = host_w[PIW-1:0];
   assign host_bit = host_vld ? NPORT'(1) << host_idx : '0;

   // Read mux; unmapped or misaligned reads return zero
   wire [DW-1:0] rd_ctrl = DW'(ctrl_q[cidx]);
   wire [DW-1:0] rd_host = DW'({host_vld, host_idx});
   wire [DW-1:0] rd_fl   = DW'({flush_rej_q, 2'h0, flush_map_q});
   wire [DW-1:0] rd_mux  = ctrl_hit ? rd_ctrl :
                           stat_hit ? stat_word :
                           host_hit ? rd_host :
                           fl_hit   ? rd_fl   : '0;

   // Stage read data and error in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
         err_q   <= 1'b0;
      end else if (setup) begin
         rdata_q <= rd_mux;
         err_q   <= !any_hit;
      end
   end

   // ***********************************
   // Table flush requests
   // ***********************************
   wire [NPORT-1:0] fl_req = pwdata[NPORT-1:0] & ~host_bit;
   // flush only ports whose learning is disabled
   wire [NPORT-1:0] fl_acc = fl_req & bk.cfg_ld;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_stb_q <= 1'b0;
         flush_map_q <= '0;
         flush_rej_q <= '0;
      end else begin
         flush_stb_q <= fl_wr && fl_acc != '0;
         if (fl_wr) begin
            flush_map_q <= fl_acc;
            flush_rej_q <= fl_req & ~bk.cfg_ld;
         end
      end
   end

   assign flush_stb = flush_stb_q;
   assign flush_map = flush_map_q;

   // ***********************************
   // Forwarding decision
   // ***********************************
   wire             src_ok   = fwd_src < PIW'(NPORT);
   wire [NPORT-1:0] src_bit  = src_ok ? NPORT'(1) << fwd_src : '0;
   wire             src_host = host_vld && src_ok && fwd_src == host_idx;
   wire             src_rx   = |(src_bit & bk.eff_rx);
   wire             src_ld   = |(src_bit & bk.eff_ld);
   wire             tag_look = fwd_tag[TT_LOOKUP];
   wire             tag_ovr  = fwd_tag[TT_OVR];
   wire [NPORT-1:0] tag_map  = fwd_tag[TT_MAP_LSB +: NPORT];
   wire             tag_force = src_host && !tag_look && tag_ovr;
   // the host port is never held back by its own bits
   wire [NPORT-1:0] tx_ok    = bk.eff_tx | host_bit;

   // host frames follow its tag or the normal lookup
   wire [NPORT-1:0] map_host = tag_look ? fwd_dmap & tx_ok :
                               tag_ovr  ? tag_map : tag_map & tx_ok;
   // open receive: normal lookup, egress gated by transmit
   wire [NPORT-1:0] map_fwd  = fwd_dmap & tx_ok;
   // closed receive: override hit reaches only the host
   wire [NPORT-1:0] map_ovr  = fwd_dmap & host_bit;
   // closed receive, no override hit: dropped
   wire [NPORT-1:0] map_edge = !src_ok   ? '0 :
                               src_rx    ? map_fwd :
                               fwd_ovr   ? map_ovr : '0;
   wire [NPORT-1:0] map_sel  = (src_host ? map_host : map_edge) & ~src_bit;
   wire             learn_sel = src_ok && (src_host || !src_ld);

   logic             fwd_vld_q;
   logic [NPORT-1:0] fwd_map_q;
   logic             fwd_learn_q;

   // decisions use the frozen port state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_vld_q   <= 1'b0;
         fwd_map_q   <= '0;
         fwd_learn_q <= 1'b0;
      end else begin
         fwd_vld_q <= fwd_req;
         if (fwd_req) begin
            fwd_map_q   <= map_sel;
            fwd_learn_q <= learn_sel;
         end
      end
   end

   assign fwd_vld   = fwd_vld_q;
   assign fwd_map   = fwd_map_q;
   assign fwd_learn = fwd_learn_q;
   assign fwd_drop  = fwd_vld_q && fwd_map_q == '0;

   // ***********************************
   // Checks
   // ***********************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_rx_closed_drop: assert property (
      fwd_req && src_ok && !src_host && !src_rx && !fwd_ovr
      |=> fwd_vld && fwd_map == '0 && fwd_drop)
      else $error("closed port frame was not dropped");

   a_ovr_to_host: assert property (
      fwd_req && src_ok && !src_host && !src_rx && fwd_ovr
      |=> fwd_map == $past(fwd_dmap & host_bit & ~src_bit))
      else $error("override frame not sent to host only");

   a_learn_off: assert property (
      fwd_req && src_ok && !src_host && src_ld |=> !fwd_learn)
      else $error("learned while learning disabled");

   a_learn_on: assert property (
      fwd_req && src_ok && !src_ld |=> fwd_learn)
      else $error("learning missed while enabled");

   a_tx_gate: assert property (
      fwd_req && !tag_force |=> (fwd_map & ~$past(tx_ok)) == '0)
      else $error("frame sent to port with transmit disabled");

   a_tag_force: assert property (
      fwd_req && tag_force |=> fwd_map == $past(tag_map & ~src_bit))
      else $error("tail tag override not honoured");

   a_flush_gate: assert property (
      fl_wr |=> (flush_map & ~$past(bk.cfg_ld)) == '0
                && flush_stb == (flush_map != '0))
      else $error("flush issued for a learning port");

   a_host_unique: assert property (
      host_vld |-> $onehot(host_bit) && cfg_tt[host_idx]
                   && (cfg_tt & (host_bit - NPORT'(1))) == '0)
      else $error("host port selection wrong");

   a_vld_pulse: assert property (
      fwd_req ##1 !fwd_req |=> !fwd_vld)
      else $error("decision valid without request");

   a_bad_addr: assert property (
      setup && !any_hit ##1 access |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");

   c_tag_force:   cover property (fwd_req && tag_force ##1 fwd_vld);
   c_ovr_to_host: cover property (fwd_req && !src_rx && fwd_ovr
                                  && !src_host ##1 fwd_map != '0);
   c_flush:       cover property (flush_stb);
   c_write_held:  cover property (wr_lane0 && ctrl_hit && |bk.busy);

endmodule
`default_nettype wire

// [src/stpf_pkg.sv]
`default_nettype none
package stpf_pkg;
   localparam int NPORT = 6;
   localparam int PIW   = 3;
   localparam int AW    = 12;
   localparam int DW    = 32;
   localparam int CW    = 4;

   // ***********************************
   // Register map (byte addresses)
   // ***********************************
   localparam logic [AW-1:0] ADR_CTRL0  = 12'h000;
   localparam logic [AW-1:0] ADR_STATUS = 12'h018;
   localparam logic [AW-1:0] ADR_HOST   = 12'h01c;
   localparam logic [AW-1:0] ADR_FLUSH  = 12'h020;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 4;

   // Port control fields
   localparam int B_TXEN = 0;
   localparam int B_RXEN = 1;
   localparam int B_LDIS = 2;
   localparam int B_TTEN = 3;
   localparam logic [CW-1:0] CTRL_RST = 4'h3;

   // Status and readback fields
   localparam int ST_MODE_W    = 2;
   localparam int ST_BUSY_LSB  = 16;
   localparam int HOST_VLD_BIT = 3;
   localparam int FL_REJ_LSB   = 8;

   // Host-to-switch tail tag fields
   localparam int TT_W       = 16;
   localparam int TT_LOOKUP  = 10;
   localparam int TT_OVR     = 9;
   localparam int TT_MAP_LSB = 0;

   // State bit encodings {ldis, rxen, txen}
   localparam logic [2:0] ENC_DISCARD = 3'h4;
   localparam logic [2:0] ENC_LEARN   = 3'h0;
   localparam logic [2:0] ENC_FWD     = 3'h3;

   typedef enum logic [1:0] {
      STPF_DISCARD,
      STPF_LEARN,
      STPF_FWD,
      STPF_ODD
   } stpf_mode_t;
endpackage
`default_nettype wire

// [src/stpf_bank_if.sv]
`default_nettype none
interface stpf_bank_if;
   import stpf_pkg::*;
   logic [NPORT-1:0] cfg_tx;
   logic [NPORT-1:0] cfg_rx;
   logic [NPORT-1:0] cfg_ld;
   logic [NPORT-1:0] sof;
   logic [NPORT-1:0] eof;
   logic [NPORT-1:0] eff_tx;
   logic [NPORT-1:0] eff_rx;
   logic [NPORT-1:0] eff_ld;
   logic [NPORT-1:0] busy;
   modport bank (input cfg_tx, cfg_rx, cfg_ld, sof, eof,
                 output eff_tx, eff_rx, eff_ld, busy);
   modport ctrl (output cfg_tx, cfg_rx, cfg_ld, sof, eof,
                 input eff_tx, eff_rx, eff_ld, busy);
endinterface
`default_nettype wire

// [src/stpf_port_bank.sv]
`default_nettype none
module stpf_port_bank
   import stpf_pkg::*;
(
   input  wire logic     pclk,
   input  wire logic     presetn,
   stpf_bank_if.bank     bk
);

   // ***********************************
   // Per-port frame-stable state copies
   // ***********************************
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic       busy_q;
      logic [2:0] eff_q;
      wire        load = !busy_q && !bk.sof[p];

      // Frame tracking; a new start wins over an end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            busy_q <= 1'b0;
         end else if (bk.sof[p]) begin
            busy_q <= 1'b1;
         end else if (bk.eof[p]) begin
            busy_q <= 1'b0;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            eff_q <= {CTRL_RST[B_LDIS], CTRL_RST[B_RXEN], CTRL_RST[B_TXEN]};
         end else if (load) begin
            eff_q <= {bk.cfg_ld[p], bk.cfg_rx[p], bk.cfg_tx[p]};
         end
      end

      assign bk.eff_tx[p] = eff_q[0];
      assign bk.eff_rx[p] = eff_q[1];
      assign bk.eff_ld[p] = eff_q[2];
      assign bk.busy[p]   = busy_q;

      a_eff_frozen: assert property (@(posedge pclk) disable iff (!presetn)
         ($past(busy_q) || $past(bk.sof[p])) |-> eff_q == $past(eff_q))
         else $error("port state changed inside a frame");
   end

endmodule
`default_nettype wire

// [verif/stpf_host_model.sv]
`default_nettype none
// ***********************************
// Host processor stand-in
// ***********************************
module stpf_host_model
   import stpf_pkg::*;
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      fwd_vld,
   input  wire logic [stpf_pkg::NPORT-1:0] fwd_map,
   input  wire logic [stpf_pkg::PIW-1:0]   src,
   input  wire logic [stpf_pkg::NPORT-1:0] ld_map,
   output logic [stpf_pkg::NPORT-1:0]      allow_map,
   output logic [15:0]                     kept,
   output logic [15:0]                     tossed
);
   assign allow_map = ~ld_map; // Discarding ports get no host frames

   // discard from discarding ports
   // Override hits from a discarding port are counted, never used
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kept <= 16'h0;
         tossed <= 16'h0;
      end else if (fwd_vld && fwd_map[0] && src != 3'h0) begin
         if (ld_map[src]) tossed <= tossed + 16'h1;
         else kept <= kept + 16'h1;
      end
   end
endmodule
`default_nettype wire

// [verif/spanning_tree_port_state_filter_test.sv]
`default_nettype none
module spanning_tree_port_state_filter_test;
   timeunit 1ns;
   timeprecision 1ps;
   import stpf_pkg::*;
   localparam int LIM = 20000;
   logic             pclk, presetn, psel, penable, pwrite, fwd_req, fwd_ovr;
   logic             pready, pslverr, fwd_vld, fwd_learn, fwd_drop, err;
   logic             flush_stb, host_vld;
   logic [AW-1:0]    paddr;
   logic [DW-1:0]    pwdata, prdata, rs, rd;
   logic [3:0]       pstrb;
   logic [NPORT-1:0] port_sof, port_eof, fwd_dmap, fwd_map, flush_map;
   logic [NPORT-1:0] tx_m, rx_m, ld_m, allow;
   logic [PIW-1:0]   fwd_src, host_idx;
   logic [TT_W-1:0]  fwd_tag;
   logic [15:0]      kept, tossed;
   int               failures, samples_checked;
   int               cyc = 0;

   // ***********************************
   // Design and host stand-in
   // ***********************************
   stpf_filter DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_sof(port_sof), .port_eof(port_eof), .fwd_req(fwd_req),
      .fwd_src(fwd_src), .fwd_dmap(fwd_dmap), .fwd_ovr(fwd_ovr),
      .fwd_tag(fwd_tag), .fwd_vld(fwd_vld), .fwd_map(fwd_map),
      .fwd_learn(fwd_learn), .fwd_drop(fwd_drop), .flush_stb(flush_stb),
      .flush_map(flush_map), .host_vld(host_vld), .host_idx(host_idx));
   stpf_host_model host (.pclk(pclk), .presetn(presetn), .fwd_vld(fwd_vld),
      .fwd_map(fwd_map), .src(fwd_src), .ld_map(ld_m), .allow_map(allow),
      .kept(kept), .tossed(tossed));

   // Clock and hang guard
   initial begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == LIM) begin
         failures++;
         tally_and_finish;
      end
   end

   // ***********************************
   // Helpers
   // ***********************************
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_map(input logic [5:0] g, input logic [5:0] e);
      chk_reg({26'h0, g}, {26'h0, e});
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_reg({31'h0, g}, {31'h0, e});
   endtask
   // APB master: hold the request until pready is seen high
   task automatic apb(input logic w, input logic [AW-1:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && cyc < LIM) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic set_port(input int p, input logic [3:0] v);
      apb(1'h1, 12'(4 * p), {28'h0, v}, rd, err);
      tx_m[p] = v[0];
      rx_m[p] = v[1];
      ld_m[p] = v[2];
      repeat (2) @(posedge pclk); // Effective copy lands one edge on
   endtask
   function automatic logic [31:0] exp_status(input logic [5:0] bsy);
      logic [31:0] r;
      logic [2:0]  v;
      r = {10'h0, bsy, 16'h0};
      for (int p = 0; p < NPORT; p++) begin
         v = {ld_m[p], rx_m[p], tx_m[p]};
         r[2*p +: 2] = v == ENC_DISCARD ? 2'h0 : v == ENC_LEARN ? 2'h1 :
                       v == ENC_FWD ? 2'h2 : 2'h3;
      end
      return r;
   endfunction
   // Host is port 0; returns {learn, egress map}
   function automatic logic [6:0] exp_fwd(input logic [2:0] s,
      input logic [5:0] dm, input logic o, input logic [15:0] t);
      logic [5:0] ok, m;
      ok = tx_m | 6'h01;
      if (s > 3'h5) return 7'h00;
      if (s == 3'h0)
         m = t[TT_LOOKUP] ? dm & ok : t[TT_OVR] ? t[5:0] : t[5:0] & ok;
      else if (rx_m[s]) m = dm & ok;
      else m = o ? dm & 6'h01 : 6'h00;
      m[s] = 1'h0;
      return {s == 3'h0 || !ld_m[s], m};
   endfunction
   task automatic fwd(input logic [2:0] s, input logic [5:0] dm,
                      input logic o, input logic [15:0] t);
      logic [6:0] x;
      x = exp_fwd(s, dm, o, t);
      @(posedge pclk);
      fwd_req <= 1'h1;
      fwd_src <= s;
      fwd_dmap <= dm;
      fwd_ovr <= o;
      fwd_tag <= t;
      @(posedge pclk);
      fwd_req <= 1'h0;
      #1;
      chk_bit(fwd_vld, 1'h1);
      chk_map(fwd_map, x[5:0]);
      chk_bit(fwd_learn, x[6]);
      chk_bit(fwd_drop, x[5:0] == 6'h00);
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ***********************************
   // Main sequence
   // ***********************************
   initial begin
      logic [31:0] r;
      logic [15:0] t;
      logic [3:0]  st [NPORT] = '{4'hb, 4'h4, 4'h0, 4'h3, 4'h4, 4'h3};
      rs = 32'h40;
      {presetn, psel, penable, pwrite, fwd_req, fwd_ovr} = 6'h0;
      {paddr, pwdata, pstrb, fwd_src, fwd_tag} = '0;
      {port_sof, port_eof, fwd_dmap} = '0;
      {failures, samples_checked} = '0;
      tx_m = 6'h3f;
      rx_m = 6'h3f;
      ld_m = 6'h00;
      pstrb = 4'hf;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      for (int p = 0; p < NPORT; p++) begin
         apb(1'h0, 12'(4 * p), 32'h0, rd, err);
         chk_reg(rd, {28'h0, CTRL_RST});
      end
      apb(1'h0, ADR_HOST, 32'h0, rd, err);
      chk_reg(rd, 32'h0);
      chk_bit(err, 1'h0);
      chk_bit(pready, 1'h1);
      apb(1'h0, 12'h024, 32'h0, rd, err);
      chk_bit(err, 1'h1);
      chk_reg(rd, 32'h0);
      // Host on port 0, the other ports in the discard, learn and forward states
      for (int p = 0; p < NPORT; p++) set_port(p, st[p]);
      chk_bit(host_vld, 1'h1);
      chk_map({3'h0, host_idx}, 6'h0);
      apb(1'h0, ADR_STATUS, 32'h0, rd, err);
      chk_reg(rd, exp_status(6'h0));
      fwd(3'h1, 6'h3f, 1'h1, 16'h0);
      fwd(3'h1, 6'h3f, 1'h0, 16'h0);
      fwd(3'h0, 6'h00, 1'h0, 16'h023e);
      fwd(3'h2, 6'h3f, 1'h1, 16'h0);
      // Random traffic; host honours the allowed map unless overriding
      repeat (300) begin
         r = xs();
         t = 16'(xs());
         if (!t[TT_OVR]) t[5:0] = t[5:0] & allow;
         fwd(r[2:0], r[8:3], r[9], t);
      end
      // State change during a frame on port 3
      @(posedge pclk);
      port_sof <= 6'h08;
      @(posedge pclk);
      port_sof <= 6'h00;
      apb(1'h1, 12'h00c, 32'h4, rd, err);
      repeat (2) @(posedge pclk);
      apb(1'h0, ADR_STATUS, 32'h0, rd, err);
      chk_reg(rd, exp_status(6'h08));
      fwd(3'h3, 6'h3f, 1'h0, 16'h0);
      @(posedge pclk);
      port_eof <= 6'h08;
      @(posedge pclk);
      port_eof <= 6'h00;
      {ld_m[3], rx_m[3], tx_m[3]} = 3'h4;
      repeat (3) @(posedge pclk);
      fwd(3'h3, 6'h3f, 1'h0, 16'h0);
      // Flush: only non-host ports with learning disabled
      apb(1'h1, ADR_FLUSH, 32'h3f, rd, err);
      #1;
      chk_bit(flush_stb, 1'h1);
      chk_map(flush_map, 6'h1a);
      apb(1'h0, ADR_FLUSH, 32'h0, rd, err);
      chk_reg(rd, 32'h241a);
      chk_bit(tossed != 16'h0, 1'h1);
      chk_bit(kept != 16'h0, 1'h1);
      tally_and_finish;
   end
endmodule
`default_nettype wire
